// *** include/scs_defs.svh ***
// Register offsets, field positions and reset values of the clock source select block
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_ADDR_W          12
`define SCS_SYSCFG_ADDR     12'h000
`define SCS_LOOPCFG_ADDR    12'h004
`define SCS_PRESC_ADDR      12'h008
`define SCS_STATUS_ADDR     12'h00c

`define SCS_SEL_MSB         1
`define SCS_SEL_LSB         0
`define SCS_BYP_BIT         0
`define SCS_REFSEL_BIT      1
`define SCS_LOOP_INPUT_DIVIDER_FIELD_MSB        5
`define SCS_LOOP_INPUT_DIVIDER_FIELD_LSB        2
`define SCS_LOOP_FEEDBACK_FACTOR_FIELD_MSB        13
`define SCS_LOOP_FEEDBACK_FACTOR_FIELD_LSB        6
`define SCS_K2_MSB          23
`define SCS_K2_LSB          14
`define SCS_K1_MSB          9
`define SCS_K1_LSB          0
`define SCS_CNT_LSB         16

`define SCS_SEL_WAKE        2'h0
`define SCS_SEL_RSVD        2'h1
`define SCS_SEL_LOOP        2'h2
`define SCS_SEL_DIRECT      2'h3

`define SCS_SEL_RST         2'h0
`define SCS_BYP_RST         1'h1
`define SCS_REFSEL_RST      1'h0
`define SCS_LOOP_INPUT_DIVIDER_FIELD_RST        4'h0
`define SCS_LOOP_FEEDBACK_FACTOR_FIELD_RST        8'h00
`define SCS_K2_RST          10'h000
`define SCS_K1_RST          10'h000
`define SCS_ACC_MAX         12'hfff

`endif

// *** include/scs_pkg.sv ***
// Types shared by the clock source select block
package scs_pkg;

    typedef enum logic [3:0] {
        SCS_WAKE   = 4'b0001,
        SCS_PRE    = 4'b0010,
        SCS_LOOP   = 4'b0100,
        SCS_DIRECT = 4'b1000
    } scs_mode_e;

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick_out;
    } scs_div_s;

    typedef struct packed {
        logic [1:0]  sel;
        logic        byp;
        logic        refsel;
        logic [3:0]  loop_input_divider_field;
        logic [7:0]  loop_feedback_factor_field;
        logic [9:0]  k2;
        logic [9:0]  k1;
        scs_mode_e   mode;
        logic [11:0] acc;
        logic        sys_tick;
        logic [15:0] tick_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scs_main_s;

    // Mode from select field and bypass bit; select 01 never reaches here
    function automatic scs_mode_e scs_mode_of(input logic [1:0] sel, input logic byp);
        scs_mode_e m;
        m = SCS_WAKE;
        case (sel)
            2'h3:    m = SCS_DIRECT;
            2'h2:    m = byp ? SCS_PRE : SCS_LOOP;
            default: m = SCS_WAKE;
        endcase
        return m;
    endfunction

endpackage

// *** include/scs_div_if.sv ***
// Tick divider connection between the main block and its divider instances
interface scs_div_if;
    logic       tick_in;
    logic [9:0] factor;
    logic       clear;
    logic       tick_out;

    modport ctrl (output tick_in, output factor, output clear, input tick_out);
    modport div  (input tick_in, input factor, input clear, output tick_out);
endinterface

// *** hw/scs_tick_divider.sv ***
// Tick divider: one output tick per factor+1 input ticks
module scs_tick_divider
    import scs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    scs_div_if.div    dv
);

    scs_div_s st;
    scs_div_s next_st;

    always_comb begin
        next_st          = st;
        next_st.tick_out = 1'b0;
        if (dv.clear) begin
            next_st.cnt = 10'h000;
        end else if (dv.tick_in) begin
            if (st.cnt >= dv.factor) begin
                next_st.cnt      = 10'h000;
                next_st.tick_out = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dv.tick_out = st.tick_out;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    div_period_a: assert property (
        (dv.tick_in && !dv.clear && st.cnt == dv.factor) |=> (dv.tick_out && st.cnt == 10'h000))
        else $error("Divider missed its terminal count");

    div_cause_a: assert property (
        dv.tick_out |-> ($past(dv.tick_in) && !$past(dv.clear)))
        else $error("Divider ticked without an input tick");

endmodule

// *** hw/scs_clock_select.sv ***
// System clock source select with prescaler, loop model and APB registers
//
// What this block does
// - Select 11 passes external clock ticks straight through
// - Select 10, bypass 1 divides oscillator by field+1
// - Prescale factor one passes oscillator ticks unchanged
// - Prescaler reaches division by 1024 at most
// - Select 10, bypass 0 runs the loop output
// - Loop rate is N over P times K2
// - Loop reference is crystal or on-chip source
// - Loop output rate steps at once on a new N, P or K2, with no ramp
// - Select 00 runs from the wakeup oscillator
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "scs_defs.svh"

module scs_clock_select
    import scs_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire logic [`SCS_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   external_clock_input,
    input  wire logic                   crystal_input_pin,
    input  wire logic                   onchip_tick,
    input  wire logic                   wakeup_tick,
    output logic                        sys_clk_en
);

    scs_main_s st;
    scs_main_s next_st;

    logic      wr_en;
    logic      setup;
    logic      osc_tick;
    logic      mode_change;
    logic      mapped;
    scs_mode_e next_mode;
    logic [12:0] acc_sum;
    logic [12:0] k2_fac;

    scs_div_if dv [2] ();

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler (index 0) and loop input divider (index 1)
    generate
        for (genvar i = 0; i < 2; i++) begin : g_div
            scs_tick_divider u_div (
                .mclk (mclk),
                .srst (srst),
                .dv   (dv[i])
            );
        end
    endgenerate

    // Same source mux for prescaler and loop reference
    assign osc_tick = st.refsel ? onchip_tick : crystal_input_pin;

    assign dv[0].tick_in = (st.mode == SCS_PRE) && osc_tick;
    assign dv[0].factor  = st.k1;
    assign dv[0].clear   = mode_change || (st.mode != SCS_PRE);
    assign dv[1].tick_in = (st.mode == SCS_LOOP) && osc_tick;
    assign dv[1].factor  = {6'h00, st.loop_input_divider_field};
    assign dv[1].clear   = mode_change || (st.mode != SCS_LOOP);

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_comb begin
        case (paddr)
            `SCS_SYSCFG_ADDR:  mapped = 1'b1;
            `SCS_LOOPCFG_ADDR: mapped = 1'b1;
            `SCS_PRESC_ADDR:   mapped = 1'b1;
            `SCS_STATUS_ADDR:  mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st          = st;
        next_st.sys_tick = 1'b0;
        next_st.pready   = setup;
        next_st.pslverr  = setup && !mapped;
        next_st.prdata   = 32'h0000_0000;
        acc_sum          = 13'h0000;
        k2_fac           = {3'h0, st.k2} + 13'h0001;

        if (setup && !pwrite) begin
            case (paddr)
                `SCS_SYSCFG_ADDR:  next_st.prdata = {30'h0, st.sel};
                `SCS_LOOPCFG_ADDR: next_st.prdata = {8'h00, st.k2, st.loop_feedback_factor_field, st.loop_input_divider_field,
                                                     st.refsel, st.byp};
                `SCS_PRESC_ADDR:   next_st.prdata = {22'h0, st.k1};
                `SCS_STATUS_ADDR:  next_st.prdata = {st.tick_cnt, 12'h000, st.mode};
                default:           next_st.prdata = 32'h0000_0000;
            endcase
        end

        // Writes land only at the completing edge of the access phase
        if (wr_en && !pslverr) begin
            case (paddr)
                `SCS_SYSCFG_ADDR: begin
                    // Undefined source code is dropped, not switched to
                    if (pwdata[`SCS_SEL_MSB:`SCS_SEL_LSB] != `SCS_SEL_RSVD) begin
                        next_st.sel = pwdata[`SCS_SEL_MSB:`SCS_SEL_LSB];
                    end
                end
                `SCS_LOOPCFG_ADDR: begin
                    next_st.byp    = pwdata[`SCS_BYP_BIT];
                    next_st.refsel = pwdata[`SCS_REFSEL_BIT];
                    next_st.loop_input_divider_field   = pwdata[`SCS_LOOP_INPUT_DIVIDER_FIELD_MSB:`SCS_LOOP_INPUT_DIVIDER_FIELD_LSB];
                    next_st.loop_feedback_factor_field   = pwdata[`SCS_LOOP_FEEDBACK_FACTOR_FIELD_MSB:`SCS_LOOP_FEEDBACK_FACTOR_FIELD_LSB];
                    next_st.k2     = pwdata[`SCS_K2_MSB:`SCS_K2_LSB];
                end
                `SCS_PRESC_ADDR: begin
                    next_st.k1 = pwdata[`SCS_K1_MSB:`SCS_K1_LSB];
                end
                default: begin
                end
            endcase
        end

        next_mode    = scs_mode_of(next_st.sel, next_st.byp);
        next_st.mode = next_mode;

        // System clock enable per mode
        case (st.mode)
            SCS_DIRECT: next_st.sys_tick = external_clock_input;
            SCS_PRE:    next_st.sys_tick = dv[0].tick_out;
            SCS_WAKE:   next_st.sys_tick = wakeup_tick;
            SCS_LOOP: begin
                // Accumulator adds N per divided reference tick and drains K2 per
                // output tick, so the output rate averages N/(P*K2)
                acc_sum = {1'b0, st.acc} + (dv[1].tick_out
                          ? {5'h00, st.loop_feedback_factor_field} + 13'h0001 : 13'h0000);
                if (acc_sum >= k2_fac) begin
                    acc_sum          = acc_sum - k2_fac;
                    next_st.sys_tick = 1'b1;
                end
                // Saturate rather than wrap when the loop is asked to exceed mclk
                if (acc_sum > {1'b0, `SCS_ACC_MAX}) begin
                    next_st.acc = `SCS_ACC_MAX;
                end else begin
                    next_st.acc = acc_sum[11:0];
                end
            end
            default: next_st.sys_tick = 1'b0;
        endcase

        if ((next_mode != st.mode) || st.mode != SCS_LOOP) begin
            next_st.acc = 12'h000;
        end

        if (next_st.sys_tick) begin
            next_st.tick_cnt = st.tick_cnt + 16'h0001;
        end
    end

    assign mode_change = (next_mode != st.mode);

    always_ff @(posedge mclk) begin
        if (srst) begin
            st          <= '0;
            st.sel      <= `SCS_SEL_RST;
            st.byp      <= `SCS_BYP_RST;
            st.refsel   <= `SCS_REFSEL_RST;
            st.loop_input_divider_field     <= `SCS_LOOP_INPUT_DIVIDER_FIELD_RST;
            st.loop_feedback_factor_field     <= `SCS_LOOP_FEEDBACK_FACTOR_FIELD_RST;
            st.k2       <= `SCS_K2_RST;
            st.k1       <= `SCS_K1_RST;
            st.mode     <= SCS_WAKE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata     = st.prdata;
    assign pready     = st.pready;
    assign pslverr    = st.pslverr;
    assign sys_clk_en = st.sys_tick;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_quiet;
        !wr_en;
    endsequence

    sequence s_unity_pre;
        st.mode == SCS_PRE && st.k1 == 10'h000;
    endsequence

    direct_follow_a: assert property (
        (st.mode == SCS_DIRECT) |=> (sys_clk_en == $past(external_clock_input)))
        else $error("Direct drive did not follow the external clock");

    prescale_unity_a: assert property (
        (s_unity_pre and osc_tick and s_quiet) ##1 (s_unity_pre and s_quiet) |=> sys_clk_en)
        else $error("Unity prescale dropped an oscillator tick");

    prescale_gate_a: assert property (
        ((st.mode == SCS_PRE && !dv[0].tick_out) and s_quiet) |=> !sys_clk_en)
        else $error("Prescaler gave a tick without a divider output");

    mode_decode_a: assert property (
        (wr_en && paddr == `SCS_LOOPCFG_ADDR && !pslverr && st.sel == `SCS_SEL_LOOP
         && !pwdata[`SCS_BYP_BIT]) |=> (st.mode == SCS_LOOP))
        else $error("Loop mode not entered with bypass cleared");

    wake_follow_a: assert property (
        (st.mode == SCS_WAKE && wakeup_tick) |=> sys_clk_en)
        else $error("Wakeup tick not passed to the system clock");

    reserved_keep_a: assert property (
        (wr_en && paddr == `SCS_SYSCFG_ADDR && pwdata[1:0] == 2'h1) |=> $stable(st.sel))
        else $error("Reserved select changed the clock source");

    loop_drain_a: assert property (
        ((st.mode == SCS_LOOP && {1'b0, st.acc} >= k2_fac) and s_quiet) |=> sys_clk_en)
        else $error("Loop accumulator full but no output tick");

    loop_smooth_a: assert property (
        ((st.mode == SCS_LOOP && !dv[1].tick_out) and s_quiet) |=> (st.acc <= $past(st.acc)))
        else $error("Loop accumulator rose without a reference tick");

    loop_ref_a: assert property (
        ((st.mode == SCS_LOOP && st.refsel && st.loop_input_divider_field == 4'h0 && onchip_tick) and s_quiet)
        |=> dv[1].tick_out)
        else $error("On-chip reference tick not seen by the loop");

    apb_ready_a: assert property (
        (psel && !penable) |=> (pready ##1 !pready))
        else $error("APB ready not a single access cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers last one cycle; refused writes must leave the setup untouched

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_bad_write;
        wr_en && (pslverr || paddr == `SCS_STATUS_ADDR);
    endsequence

    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("Bus error raised outside an access cycle");

    rdata_idle_a: assert property (
        !pready |-> (prdata == 32'h0000_0000))
        else $error("Read data left on the bus after the access");

    unmapped_err_a: assert property (
        (s_setup and !mapped) |=> (pready && pslverr))
        else $error("Unmapped address answered without an error");

    sel_read_a: assert property (
        (s_setup and (!pwrite && paddr == `SCS_SYSCFG_ADDR))
        |=> (prdata == {30'h0, $past(st.sel)}))
        else $error("Select field read back wrong");

    bad_write_a: assert property (
        s_bad_write |=> ($stable(st.sel) && $stable(st.byp) && $stable(st.k1)
                         && $stable(st.k2) && $stable(st.loop_feedback_factor_field) && $stable(st.loop_input_divider_field)))
        else $error("Refused write changed the configuration");

    ////////////////////////////////////////////////////////////////////////////
    // Mode and tick bookkeeping; a one-hot slip would stall every consumer

    mode_onehot_a: assert property (
        $onehot(st.mode))
        else $error("Clock mode is not one-hot");

    loop_match_a: assert property (
        (st.mode == SCS_LOOP) |-> (st.sel == `SCS_SEL_LOOP && !st.byp))
        else $error("Loop mode without select 10 and bypass 0");

    pre_match_a: assert property (
        (st.mode == SCS_PRE) |-> (st.sel == `SCS_SEL_LOOP && st.byp))
        else $error("Prescale mode without select 10 and bypass 1");

    acc_idle_a: assert property (
        (st.mode != SCS_LOOP) |-> (st.acc == 12'h000))
        else $error("Loop accumulator holds a value outside loop mode");

    tick_count_a: assert property (
        st.tick_cnt == $past(st.tick_cnt) + {15'h0000, sys_clk_en})
        else $error("Status tick count out of step with the clock enable");

    wake_gate_a: assert property (
        (st.mode == SCS_WAKE && !wakeup_tick) |=> !sys_clk_en)
        else $error("Wakeup mode ticked without a wakeup tick");

    prescale_pass_a: assert property (
        (st.mode == SCS_PRE && dv[0].tick_out) |=> sys_clk_en)
        else $error("Prescaler output tick lost");

endmodule

// *** testbench/scs_src_model.sv ***
// Clock source model: tick enables for external, crystal, on-chip and wakeup sources
module scs_src_model (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic [7:0] periods,
    output logic      [3:0] ticks
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt [4];
    // Sources stand still while stopped, so no stray tick crosses a mode change
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (srst || !run) begin
                cnt[i]   <= 2'h0;
                ticks[i] <= 1'b0;
            end else begin
                ticks[i] <= (cnt[i] == periods[2*i +: 2]);
                cnt[i]   <= (cnt[i] == periods[2*i +: 2]) ? 2'h0 : cnt[i] + 2'h1;
            end
        end
    end
endmodule

// *** testbench/testbench.sv ***
// Self-checking testbench for the clock source select block
`include "scs_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////////////////
module testbench
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [32:0] FULL = 33'h1_ffff_ffff;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, sys_clk_en, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  periods;
    logic [3:0]  ticks;
    logic [15:0] rnd;
    logic [32:0] exp_q [$];
    logic [32:0] msk_q [$];
    logic [32:0] exp_v, msk_v;
    int          err_count, n_compared, sel_ticks, pulses, src_idx, cyc;
    int          kf [4];

    scs_clock_select scs_clock_select_inst (.mclk, .srst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .external_clock_input(ticks[0]),
        .crystal_input_pin(ticks[1]), .onchip_tick(ticks[2]), .wakeup_tick(ticks[3]),
        .sys_clk_en);
    scs_src_model scs_src_model_inst (.mclk, .srst, .run, .periods, .ticks);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; a read queues its expected {pslverr, prdata} and mask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        if (!wr) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Park on the slow wakeup clock before touching dividers
    task automatic cfg(input logic [31:0] lc, input logic [9:0] k1);
        apb(1'b1, `SCS_SYSCFG_ADDR, 32'h0, '0, '0);
        apb(1'b1, `SCS_LOOPCFG_ADDR, lc, '0, '0);
        apb(1'b1, `SCS_PRESC_ADDR, {22'h0, k1}, '0, '0);
    endtask

    // Select a source, run ticks of all sources, compare output pulses with the rate
    task automatic rate(input logic [1:0] sel, input int idx, input scs_mode_e md,
                        input int t);
        int e;
        rnd = lfsr(rnd);
        periods <= rnd[7:0];
        apb(1'b1, `SCS_SYSCFG_ADDR, {30'h0, sel}, '0, '0);
        repeat (3) @(posedge mclk);
        src_idx = idx;
        sel_ticks = 0;
        pulses = 0;
        run <= 1'b1;
        while (sel_ticks < t) begin
            @(posedge mclk);
        end
        run <= 1'b0;
        repeat (40) @(posedge mclk);
        case (md)
            SCS_PRE:  e = sel_ticks / kf[0];
            SCS_LOOP: e = (sel_ticks / kf[1]) * kf[2] / kf[3];
            default:  e = sel_ticks;
        endcase
        `CHK(pulses, e)
        apb(1'b0, `SCS_STATUS_ADDR, 32'h0, {29'h0, md}, 33'h1_0000_ffff);
        $display("test mode %0h done", md);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cyc++;
        if (ticks[src_idx] === 1'b1)
            sel_ticks++;
        if (sys_clk_en === 1'b1)
            pulses++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                exp_v = exp_q.pop_front();
                msk_v = msk_q.pop_front();
                `CHK({pslverr, prdata} & msk_v, exp_v & msk_v)
            end
        end
        if (cyc == 80000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        run = 1'b0;
        periods = '0;
        rnd = 16'hf5cf;
        kf = '{1, 1, 1, 1};
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, `SCS_SYSCFG_ADDR, 32'h0, 33'h0, FULL);
        apb(1'b0, `SCS_LOOPCFG_ADDR, 32'h0, 33'h1, FULL);
        apb(1'b0, `SCS_PRESC_ADDR, 32'h0, 33'h0, FULL);
        apb(1'b1, `SCS_STATUS_ADDR, 32'hffff_ffff, '0, '0);
        apb(1'b0, `SCS_STATUS_ADDR, 32'h0, {29'h0, SCS_WAKE}, FULL);
        apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000, FULL);
        $display("test reset done");
        rate(2'h3, 0, SCS_DIRECT, 30);
        rate(2'h0, 3, SCS_WAKE, 20);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            kf[0] = (i == 0) ? 1 : (i == 1) ? 1024 : int'(rnd[3:0]) + 1;
            cfg({30'h0, rnd[4], 1'b1}, 10'(kf[0] - 1));
            rate(2'h2, rnd[4] ? 2 : 1, SCS_PRE, 2 * kf[0]);
        end
        for (int i = 0; i < 2; i++) begin
            kf[1] = 2 - i;
            kf[2] = 3 - 2 * i;
            kf[3] = 2 - i;
            cfg({8'h0, 10'(kf[3] - 1), 8'(kf[2] - 1), 4'(kf[1] - 1), i[0], 1'b0}, 10'h0);
            rate(2'h2, i ? 2 : 1, SCS_LOOP, 40);
        end
        apb(1'b1, `SCS_LOOPCFG_ADDR, 32'h3, '0, '0);
        apb(1'b0, `SCS_STATUS_ADDR, 32'h0, {29'h0, SCS_PRE}, 33'h1_0000_ffff);
        apb(1'b1, `SCS_LOOPCFG_ADDR, 32'h2, '0, '0);
        apb(1'b0, `SCS_LOOPCFG_ADDR, 32'h0, 33'h2, FULL);
        apb(1'b1, `SCS_SYSCFG_ADDR, 32'h1, '0, '0);
        apb(1'b0, `SCS_SYSCFG_ADDR, 32'h0, 33'h2, FULL);
        apb(1'b0, `SCS_STATUS_ADDR, 32'h0, {29'h0, SCS_LOOP}, 33'h1_0000_ffff);
        $display("test reserved done");
        repeat (5) @(posedge mclk);
        end_sim();
    end
endmodule
